// *** rtl/adcp_cfg.svh ***
`ifndef ADCP_CFG_SVH
`define ADCP_CFG_SVH

// serial word layout, address first, most significant bit first
`define ADCP_WORD_W       16
`define ADCP_ADDR_W       5
`define ADCP_DATA_W       11
`define ADCP_NREG         32
`define ADCP_REG_DEFAULT  11'h000

// serial register numbers and field positions
`define ADCP_CTRL_REG     5'h00
`define ADCP_FMT_REG      5'h0A
`define ADCP_STBY_BIT     0
`define ADCP_CLKPDN_BIT   2
`define ADCP_SOFTRST_BIT  4
`define ADCP_REF_BIT      5
`define ADCP_CMOS_BIT     8
`define ADCP_COARSE_BIT   9
`define ADCP_OBUF_BIT     10
`define ADCP_FMT_BIT      10

// apb map: serial registers mirrored at 4*address, then status
`define ADCP_MIRROR_LAST  8'h7C
`define ADCP_STATUS_OFS   8'h80
`define ADCP_APB_AW       8

// shift clock limit; a word spans 16 edges, far longer than the sync
`define ADCP_SCLK_MIN_NS  50

`endif

// *** rtl/adcp_pkg.sv ***
`default_nettype none

package adcp_pkg;

  // level of a four-level strap pin, as resolved by the pin comparator
  typedef enum logic [1:0] {
    ADCP_LVL_GND  = 2'b00,
    ADCP_LVL_3_8  = 2'b01,
    ADCP_LVL_5_8  = 2'b10,
    ADCP_LVL_FULL = 2'b11
  } adcp_lvl_t;

  typedef struct packed {
    logic [3:0]  cnt;
    logic [14:0] sh;
  } adcp_frame_t;

  typedef struct packed {
    logic [15:0] word;
    logic        tog;
  } adcp_out_t;

  typedef struct packed {
    logic [1:0]             rpin;
    logic [2:0]             rtog;
    logic [2:0]             wtog;
    logic [1:0]             pdn;
    logic [1:0]             sdat;
    adcp_lvl_t              sclv0;
    adcp_lvl_t              sclv1;
    adcp_lvl_t              senv0;
    adcp_lvl_t              senv1;
    logic [31:0][10:0]      regs;
    logic [7:0]             word_cnt;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   par_mode;
    logic                   ref_ext;
    logic                   coarse;
    logic                   out_cmos;
    logic                   fmt_bin;
    logic                   adc_stby;
    logic                   obuf_pdn;
    logic                   glob_pdn;
    logic                   clk_pdn;
  } adcp_core_t;

endpackage

`default_nettype wire

// *** rtl/adcp_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface adcp_link_if;
  logic [15:0] word;
  logic        tog;
  modport shift (output word, output tog);
  modport core  (input word, input tog);
endinterface

`default_nettype wire

// *** rtl/adcp_shift.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adcp_cfg.svh"

module adcp_shift (
  input  wire logic    shift_clk,
  input  wire logic    serial_select,
  input  wire logic    shift_data,
  input  wire logic    presetn,
  adcp_link_if.shift   lnk
);

  adcp_pkg::adcp_frame_t fs_reg;
  adcp_pkg::adcp_frame_t fs_next;
  adcp_pkg::adcp_out_t   os_reg;
  adcp_pkg::adcp_out_t   os_next;
  logic                  frame_clr_n;

  // select high ends the frame: trailing bits die with it, no clock needed
  assign frame_clr_n = presetn & ~serial_select;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    fs_next = fs_reg;
    os_next = os_reg;
    fs_next.sh  = {fs_reg.sh[13:0], shift_data};
    fs_next.cnt = fs_reg.cnt + 4'h1;
    if (fs_reg.cnt == 4'hF) begin
      os_next.word = {fs_reg.sh, shift_data};
      os_next.tog  = ~os_reg.tog;
    end
  end

  always_ff @(negedge shift_clk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      fs_reg <= '0;
    end else begin
      fs_reg <= fs_next;
    end
  end

  // any rate or duty, own domain
  always_ff @(negedge shift_clk or negedge presetn) begin
    if (!presetn) begin
      os_reg <= '0;
    end else begin
      os_reg <= os_next;
    end
  end

  assign lnk.word = os_reg.word;
  assign lnk.tog  = os_reg.tog;

  ////////////////////////////////////////////////////////////////////////
  word_commit_a: assert property (
    @(negedge shift_clk) disable iff (!frame_clr_n)
    fs_reg.cnt == 4'hF |=> os_reg.tog != $past(os_reg.tog)
      && os_reg.word[0] == $past(shift_data))
    else $error("word not committed on 16th edge");

  no_early_a: assert property (
    @(negedge shift_clk) disable iff (!frame_clr_n)
    fs_reg.cnt != 4'hF |=> $stable(os_reg.tog))
    else $error("word committed before 16th edge");

endmodule

`default_nettype wire

// *** rtl/adcp_config_top.sv ***
// Summary of operation
// - reset pin low selects serial access
// - reset pin high makes pins static straps
// - shift clock level picks reference and gain
// - select level picks format and interface
// - shift data and power-down pick power state
// - shift data sampled on falling edges, select low
// - every 16th edge commits; leftovers dropped
// - five address bits, then eleven data bits
// - shift clock up to 20 MHz, any duty
// - soft reset bit clears registers, self-clears
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "adcp_cfg.svh"

module adcp_config_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_pin,
  input  wire logic        serial_select,
  input  wire logic        shift_clk,
  input  wire logic        shift_data,
  input  wire logic        pdn_pin,
  input  wire logic [1:0]  shift_clk_lvl,
  input  wire logic [1:0]  serial_select_lvl,
  output logic             parallel_mode,
  output logic             ref_external,
  output logic             coarse_gain,
  output logic             out_cmos,
  output logic             fmt_binary,
  output logic             adc_standby,
  output logic             obuf_pdn,
  output logic             global_pdn,
  output logic             clkout_pdn
);

  adcp_pkg::adcp_core_t s_reg;
  adcp_pkg::adcp_core_t s_next;
  logic                 rst_tog_reg;
  logic                 hw_rst;
  logic                 ser_ev;
  logic [4:0]           ser_addr;
  logic [10:0]          ser_data;
  logic                 apb_setup;
  logic                 apb_wr;
  logic                 in_mirror;
  logic [4:0]           apb_idx;
  logic                 soft_rst;

  adcp_link_if lnk ();

  adcp_shift u_shift (
    .shift_clk     (shift_clk),
    .serial_select (serial_select),
    .shift_data    (shift_data),
    .presetn       (presetn),
    .lnk           (lnk)
  );

  ////////////////////////////////////////////////////////////////////////
  // a reset pulse may be far shorter than pclk, so its edge flips a
  // toggle that the pclk side then sees through a synchroniser
  always_ff @(posedge reset_pin or negedge presetn) begin
    if (!presetn) begin
      rst_tog_reg <= 1'b0;
    end else begin
      rst_tog_reg <= ~rst_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.rpin  = {s_reg.rpin[0], reset_pin};
    s_next.rtog  = {s_reg.rtog[1:0], rst_tog_reg};
    s_next.wtog  = {s_reg.wtog[1:0], lnk.tog};
    s_next.pdn   = {s_reg.pdn[0], pdn_pin};
    s_next.sdat  = {s_reg.sdat[0], shift_data};
    s_next.sclv0 = adcp_pkg::adcp_lvl_t'(shift_clk_lvl);
    s_next.sclv1 = s_reg.sclv0;
    s_next.senv0 = adcp_pkg::adcp_lvl_t'(serial_select_lvl);
    s_next.senv1 = s_reg.senv0;

    hw_rst = s_reg.rtog[2] ^ s_reg.rtog[1];
    // serial words only while reset low
    ser_ev = (s_reg.wtog[2] ^ s_reg.wtog[1]) & ~s_reg.rpin[1];
    ser_addr = lnk.word[15:11];
    ser_data = lnk.word[10:0];

    apb_setup = psel & ~penable;
    apb_wr    = psel & penable & s_reg.pready & pwrite;
    in_mirror = (paddr <= `ADCP_MIRROR_LAST) && (paddr[1:0] == 2'h0);
    apb_idx   = paddr[6:2];

    if (ser_ev) begin
      s_next.regs[ser_addr] = ser_data;
      s_next.word_cnt       = s_reg.word_cnt + 8'h01;
    end
    if (apb_wr && in_mirror) begin
      s_next.regs[apb_idx] = pwdata[10:0];
    end

    soft_rst = (ser_ev && ser_addr == `ADCP_CTRL_REG
                && ser_data[`ADCP_SOFTRST_BIT])
            || (apb_wr && in_mirror && apb_idx == `ADCP_CTRL_REG
                && pwdata[`ADCP_SOFTRST_BIT]);
    if (soft_rst || hw_rst) begin
      for (int i = 0; i < `ADCP_NREG; i++) begin
        s_next.regs[i] = `ADCP_REG_DEFAULT;
      end
    end

    // apb answers after one setup cycle, zero wait in access
    s_next.pready  = apb_setup;
    s_next.pslverr = 1'b0;
    s_next.prdata  = 32'h0000_0000;
    if (apb_setup) begin
      if (in_mirror) begin
        s_next.prdata = {21'h0, s_reg.regs[apb_idx]};
      end else if (paddr == `ADCP_STATUS_OFS && !pwrite) begin
        s_next.prdata = {23'h0, s_reg.par_mode, s_reg.word_cnt};
      end else begin
        s_next.pslverr = 1'b1;
      end
    end

    s_next.par_mode = s_reg.rpin[1];
    if (s_reg.rpin[1]) begin
      unique case (s_reg.sclv1)
        adcp_pkg::ADCP_LVL_GND: begin
          s_next.ref_ext = 1'b0;
          s_next.coarse  = 1'b0;
        end
        adcp_pkg::ADCP_LVL_3_8: begin
          s_next.ref_ext = 1'b1;
          s_next.coarse  = 1'b0;
        end
        adcp_pkg::ADCP_LVL_5_8: begin
          s_next.ref_ext = 1'b1;
          s_next.coarse  = 1'b1;
        end
        adcp_pkg::ADCP_LVL_FULL: begin
          s_next.ref_ext = 1'b0;
          s_next.coarse  = 1'b1;
        end
      endcase
      unique case (s_reg.senv1)
        adcp_pkg::ADCP_LVL_GND: begin
          s_next.fmt_bin  = 1'b0;
          s_next.out_cmos = 1'b0;
        end
        adcp_pkg::ADCP_LVL_3_8: begin
          s_next.fmt_bin  = 1'b1;
          s_next.out_cmos = 1'b0;
        end
        adcp_pkg::ADCP_LVL_5_8: begin
          s_next.fmt_bin  = 1'b1;
          s_next.out_cmos = 1'b1;
        end
        adcp_pkg::ADCP_LVL_FULL: begin
          s_next.fmt_bin  = 1'b0;
          s_next.out_cmos = 1'b1;
        end
      endcase
      s_next.adc_stby = s_reg.pdn[1] & ~s_reg.sdat[1];
      s_next.obuf_pdn = s_reg.sdat[1] & ~s_reg.pdn[1];
      s_next.glob_pdn = s_reg.sdat[1] & s_reg.pdn[1];
      s_next.clk_pdn  = 1'b0;
    end else begin
      s_next.ref_ext  = s_reg.regs[`ADCP_CTRL_REG][`ADCP_REF_BIT];
      s_next.coarse   = s_reg.regs[`ADCP_CTRL_REG][`ADCP_COARSE_BIT];
      s_next.out_cmos = s_reg.regs[`ADCP_CTRL_REG][`ADCP_CMOS_BIT];
      s_next.fmt_bin  = s_reg.regs[`ADCP_FMT_REG][`ADCP_FMT_BIT];
      s_next.adc_stby = s_reg.regs[`ADCP_CTRL_REG][`ADCP_STBY_BIT];
      s_next.obuf_pdn = s_reg.regs[`ADCP_CTRL_REG][`ADCP_OBUF_BIT];
      s_next.glob_pdn = 1'b0;
      s_next.clk_pdn  = s_reg.regs[`ADCP_CTRL_REG][`ADCP_CLKPDN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata        = s_reg.prdata;
  assign pready        = s_reg.pready;
  assign pslverr       = s_reg.pslverr;
  assign parallel_mode = s_reg.par_mode;
  assign ref_external  = s_reg.ref_ext;
  assign coarse_gain   = s_reg.coarse;
  assign out_cmos      = s_reg.out_cmos;
  assign fmt_binary    = s_reg.fmt_bin;
  assign adc_standby   = s_reg.adc_stby;
  assign obuf_pdn      = s_reg.obuf_pdn;
  assign global_pdn    = s_reg.glob_pdn;
  assign clkout_pdn    = s_reg.clk_pdn;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  soft_reset_a: assert property (
    ser_ev && ser_addr == `ADCP_CTRL_REG && ser_data[`ADCP_SOFTRST_BIT]
    |=> s_reg.regs[`ADCP_FMT_REG] == `ADCP_REG_DEFAULT
      && !s_reg.regs[`ADCP_CTRL_REG][`ADCP_SOFTRST_BIT])
    else $error("soft reset did not clear registers");

  rst_self_clear_a: assert property (
    !s_reg.regs[`ADCP_CTRL_REG][`ADCP_SOFTRST_BIT])
    else $error("soft reset bit stuck high");

  word_store_a: assert property (
    ser_ev && ser_addr != `ADCP_CTRL_REG && !hw_rst
      && !(apb_wr && in_mirror)
    |=> s_reg.regs[$past(ser_addr)] == $past(ser_data))
    else $error("serial word not stored at its address");

  serial_gate_a: assert property (
    s_reg.rpin[1] && !hw_rst && !(apb_wr && in_mirror)
    |=> $stable(s_reg.regs))
    else $error("serial write taken with reset high");

  strap_ref_a: assert property (
    s_reg.rpin[1] && s_reg.sclv1 == adcp_pkg::ADCP_LVL_5_8
    |=> ref_external && coarse_gain)
    else $error("reference strap decoded wrongly");

  strap_fmt_a: assert property (
    s_reg.rpin[1] && s_reg.senv1 == adcp_pkg::ADCP_LVL_FULL
    |=> !fmt_binary && out_cmos)
    else $error("format strap decoded wrongly");

  strap_pwr_a: assert property (
    s_reg.rpin[1] |=> global_pdn == ($past(s_reg.sdat[1])
      && $past(s_reg.pdn[1])) && parallel_mode)
    else $error("power strap decoded wrongly");

  apb_ready_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  apb_error_a: assert property (
    psel && !penable && !in_mirror
      && !(paddr == `ADCP_STATUS_OFS && !pwrite)
    |=> pready && pslverr)
    else $error("unmapped access not refused");

  error_timing_a: assert property (
    pslverr |-> pready)
    else $error("error flag outside access cycle");

  read_idle_a: assert property (
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access cycle");

  mirror_read_a: assert property (
    psel && !penable && in_mirror
    |=> prdata[10:0] == $past(s_reg.regs[apb_idx]) && prdata[31:11] == 21'h0)
    else $error("register read returned wrong word");

  status_read_a: assert property (
    psel && !penable && paddr == `ADCP_STATUS_OFS && !pwrite
    |=> prdata[8] == $past(s_reg.par_mode)
      && prdata[7:0] == $past(s_reg.word_cnt) && !pslverr)
    else $error("status word read wrongly");

  apb_write_a: assert property (
    apb_wr && in_mirror && !soft_rst && !hw_rst
    |=> s_reg.regs[$past(apb_idx)] == $past(pwdata[10:0]))
    else $error("bus write not stored");

  hw_clear_a: assert property (
    hw_rst |=> s_reg.regs == '0)
    else $error("reset pulse did not clear registers");

  word_count_a: assert property (
    ser_ev |=> s_reg.word_cnt == $past(s_reg.word_cnt) + 8'h01)
    else $error("serial word not counted");

  count_hold_a: assert property (
    !ser_ev |=> $stable(s_reg.word_cnt))
    else $error("word count moved without a word");

  mode_flag_a: assert property (
    parallel_mode == $past(s_reg.rpin[1]))
    else $error("parallel mode flag wrong");

  serial_modes_a: assert property (
    !s_reg.rpin[1]
    |=> ref_external == $past(s_reg.regs[`ADCP_CTRL_REG][`ADCP_REF_BIT])
      && fmt_binary == $past(s_reg.regs[`ADCP_FMT_REG][`ADCP_FMT_BIT])
      && !global_pdn)
    else $error("serial mode outputs not from registers");

  serial_power_a: assert property (
    !s_reg.rpin[1]
    |=> adc_standby == $past(s_reg.regs[`ADCP_CTRL_REG][`ADCP_STBY_BIT])
      && obuf_pdn == $past(s_reg.regs[`ADCP_CTRL_REG][`ADCP_OBUF_BIT])
      && clkout_pdn == $past(s_reg.regs[`ADCP_CTRL_REG][`ADCP_CLKPDN_BIT]))
    else $error("serial power outputs not from registers");

  strap_full_a: assert property (
    s_reg.rpin[1] && s_reg.sclv1 == adcp_pkg::ADCP_LVL_FULL
    |=> !ref_external && coarse_gain)
    else $error("full level reference strap wrong");

  strap_gnd_a: assert property (
    s_reg.rpin[1] && s_reg.senv1 == adcp_pkg::ADCP_LVL_GND
    |=> !fmt_binary && !out_cmos)
    else $error("ground level format strap wrong");

  strap_stby_a: assert property (
    s_reg.rpin[1] && s_reg.pdn[1] && !s_reg.sdat[1]
    |=> adc_standby && !obuf_pdn && !global_pdn)
    else $error("standby strap decoded wrongly");

  strap_obuf_a: assert property (
    s_reg.rpin[1] && s_reg.sdat[1] && !s_reg.pdn[1]
    |=> obuf_pdn && !adc_standby && !clkout_pdn)
    else $error("buffer power strap decoded wrongly");

endmodule

`default_nettype wire

// *** tb/adcp_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module adcp_host (
  output logic reset_pin,
  output logic serial_select,
  output logic shift_clk,
  output logic shift_data
);
  initial begin
    reset_pin = 1'h0;
    serial_select = 1'h1;
    shift_clk = 1'h1;
    shift_data = 1'h0;
  end

  task automatic hw_reset();
    while ($time < 5000000) #1000;
    reset_pin = 1'h1;
    #40;
    reset_pin = 1'h0;
    #30;
  endtask

  task automatic strap(input logic sd);
    reset_pin <= 1'h1;
    shift_data <= sd;
  endtask

  task automatic frame(input logic [47:0] bits, input int n);
    reset_pin = 1'h0;
    #30.3 serial_select = 1'h0;
    for (int i = 0; i < n; i++) begin
      shift_data = bits[47-i];
      #62.5 shift_clk = 1'h0;
      #62.5 shift_clk = 1'h1;
    end
    #62.5 serial_select = 1'h1;
    // released line must not keep its last value
    shift_data = ~shift_data;
  endtask
endmodule

`default_nettype wire

// *** tb/adc_config_serial_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_config_serial_port_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        reset_pin, serial_select, shift_clk, shift_data, pdn_pin;
  logic [1:0]  shift_clk_lvl, serial_select_lvl, sv;
  logic [7:0]  paddr, c;
  logic [31:0] pwdata, prdata, r;
  logic [8:0]  mode, m;
  logic [4:0]  a;
  logic [10:0] d, d2;
  int          num_errors, check_count;
  int unsigned rs;
  int          mdl [32];

  adcp_config_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin(reset_pin),
    .serial_select(serial_select), .shift_clk(shift_clk),
    .shift_data(shift_data), .pdn_pin(pdn_pin),
    .shift_clk_lvl(shift_clk_lvl), .serial_select_lvl(serial_select_lvl),
    .parallel_mode(mode[8]), .ref_external(mode[7]),
    .coarse_gain(mode[6]), .out_cmos(mode[5]), .fmt_binary(mode[4]),
    .adc_standby(mode[3]), .obuf_pdn(mode[2]), .global_pdn(mode[1]),
    .clkout_pdn(mode[0]));

  adcp_host u_host (.reset_pin(reset_pin), .serial_select(serial_select),
    .shift_clk(shift_clk), .shift_data(shift_data));

  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // taken at the edge that sees pready; a hang ends at the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic mdl_wr(input int ad, input int wd);
    if (ad == 0 && wd[4]) begin
      for (int i = 0; i < 32; i++) mdl[i] = 0;
    end else begin
      mdl[ad] = wd;
    end
  endtask

  task automatic wr(input logic [4:0] ad, input logic [10:0] wd);
    u_host.frame({ad, wd, 32'h0000_0000}, 16);
    mdl_wr(ad, wd);
    repeat (10) @(posedge pclk);
  endtask

  task automatic rd_all();
    for (int i = 0; i < 32; i++) begin
      apb(1'h0, 8'(i * 4), 32'h0);
      chk(r, mdl[i]);
      chk(e, 1'h0);
    end
  endtask

  task automatic chk_mode();
    chk(mode, {1'h0, mdl[0][5], mdl[0][9], mdl[0][8], mdl[10][10],
               mdl[0][0], mdl[0][10], 1'h0, mdl[0][2]});
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #8000000;
    num_errors++;
    close_out();
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pdn_pin = 1'h0;
    shift_clk_lvl = 2'h0;
    serial_select_lvl = 2'h0;
    num_errors = 0;
    check_count = 0;
    rs = 67458;
    for (int i = 0; i < 32; i++) mdl[i] = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    u_host.hw_reset();
    rd_all();
    apb(1'h0, 8'h84, 32'h0);
    chk(e, 1'h1);
    apb(1'h1, 8'h80, 32'h0000_00FF);
    chk(e, 1'h1);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      a = 5'(xs() % 31 + 1);
      d = 11'(xs());
      wr(a, d);
      apb(1'h0, {1'h0, a, 2'h0}, 32'h0);
      chk(r, mdl[a]);
    end
    $display("test serial writes done");
    apb(1'h0, 8'h80, 32'h0);
    c = r[7:0];
    d = 11'(xs());
    d2 = 11'(xs());
    u_host.frame({5'h03, d, 5'h04, d2, 5'h05, 11'h7FF}, 37);
    mdl[3] = d;
    mdl[4] = d2;
    repeat (10) @(posedge pclk);
    apb(1'h0, 8'h80, 32'h0);
    chk(r[7:0], 8'(c + 8'h02));
    chk(r[8], 1'h0);
    rd_all();
    $display("test multi word done");
    // a mid-run pulse clears every register
    u_host.hw_reset();
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 32; i++) mdl[i] = 0;
    rd_all();
    $display("test hardware reset done");
    // reserved bits of the control word stay zero
    d = 11'(xs()) & 11'h725;
    wr(5'h00, d);
    apb(1'h1, 8'h28, 32'h0000_0400);
    mdl[10] = 32'h400;
    chk(e, 1'h0);
    repeat (4) @(posedge pclk);
    chk_mode();
    wr(5'h00, 11'h010);
    rd_all();
    repeat (4) @(posedge pclk);
    chk_mode();
    $display("test modes and soft reset done");
    for (int i = 0; i < 16; i++) begin
      sv = i[1:0] ^ i[3:2];
      u_host.strap(sv[1]);
      @(posedge pclk);
      pdn_pin <= sv[0];
      shift_clk_lvl <= i[1:0];
      serial_select_lvl <= i[3:2];
      repeat (8) @(posedge pclk);
      m = (sv == 2'h3) ? 9'h1F2 : 9'h1FE;
      chk(mode & m, {1'h1, i[1:0] == 1 || i[1:0] == 2, i[1], i[3],
          i[3:2] == 1 || i[3:2] == 2, sv == 1, sv == 2, sv == 3,
          1'h0} & m);
    end
    apb(1'h0, 8'h80, 32'h0);
    chk(r[8], 1'h1);
    for (int i = 0; i < 32; i++) mdl[i] = 0;
    wr(5'h01, 11'h5A5);
    rd_all();
    apb(1'h0, 8'h80, 32'h0);
    chk(r[8], 1'h0);
    $display("test parallel mode done");
    close_out();
  end
endmodule

`default_nettype wire
